// >>> hw/dcr_pkg.sv
// constants and field layout of the device capability register bank
// Contract
// - memory-size register at 0x008 is read-only with a fixed part value
// - bits 31:16 of memory-size register read 0x00ff, 64 KB of ram
// - bits 15:0 of memory-size register read 0x003f, 128 KB of flash
// - feature register at 0x010 is read-only with a fixed part value
// - feature bits mask run, sleep, deep-sleep gating bits; others pass zero (code zeroes gating bits 5, 4 though feature bits 5, 4 read 1)
// - converter speed setting in gating registers clipped to feature limit
// - feature bit 5 reads 1: thermal sensor present
// - feature bit 4 reads 1: frequency synthesiser present
// - feature bit 3 reads 1: watchdog present
// - feature bits 2, 1, 0 read 1: trace, two-wire, boundary-scan debug
// - identification bits 12:8 reserved, read zero, software preserves them
// - identification bits 7:5 read-only thermal rating code
// - identification bits 4:3 read-only package type code
// - identification bit 2 reads 1: environmental compliance met
// - identification bits 1:0 read-only qualification code, value part-defined
package dcr_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_PART_ID_ONE = 12'h004;
  localparam logic [11:0] OFS_MEM_SIZE_CAP = 12'h008;
  localparam logic [11:0] OFS_FEATURE_CAP = 12'h010;

  // memory-size capability fields
  localparam logic [15:0] RAM_SIZE_CODE = 16'h00ff;
  localparam logic [15:0] NVM_SIZE_CODE = 16'h003f;
  localparam int RAM_SIZE_LSB = 16;
  localparam int NVM_SIZE_LSB = 0;

  // feature capability bit positions
  localparam int FEAT_PWM_BIT = 20;
  localparam int FEAT_CONV0_BIT = 16;
  localparam int FEAT_SPD_LSB = 8;
  localparam int FEAT_SPD_W = 2;
  localparam logic [1:0] FEAT_SPD_LIMIT = 2'h1;
  localparam int FEAT_THERM_BIT = 5;
  localparam int FEAT_SYNTH_BIT = 4;
  localparam int FEAT_WDOG_BIT = 3;
  localparam int FEAT_TRACE_BIT = 2;
  localparam int FEAT_TWD_BIT = 1;
  localparam int FEAT_BSCAN_BIT = 0;

  // identification-one fields
  localparam int ID_RSVD_LSB = 8;
  localparam int ID_THERM_LSB = 5;
  localparam int ID_PKG_LSB = 3;
  localparam int ID_ENV_BIT = 2;
  localparam int ID_QUALIFICATION_STATUS_CODE_LSB = 0;
  localparam logic [2:0] ID_THERM_CODE = 3'h1;
  localparam logic [1:0] ID_PKG_CODE = 2'h1;
  localparam logic ID_ENV_CODE = 1'b1;
  localparam logic [1:0] ID_QUALIFICATION_STATUS_CODE_DEFAULT = 2'h0;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    DCR_IDLE = 2'b01,
    DCR_ACK = 2'b10
  } dcr_bus_state_t;
endpackage

// >>> hw/dcr_gate_if.sv
// gating register values travelling between the bank and the masking unit
`timescale 1ns/1ns
interface dcr_gate_if;
  logic [31:0] feature;
  logic [31:0] run_raw;
  logic [31:0] sleep_raw;
  logic [31:0] deep_raw;
  logic [31:0] run_masked;
  logic [31:0] sleep_masked;
  logic [31:0] deep_masked;
  modport bank (output feature, output run_raw, output sleep_raw, output deep_raw,
    input run_masked, input sleep_masked, input deep_masked);
  modport mask (input feature, input run_raw, input sleep_raw, input deep_raw,
    output run_masked, output sleep_masked, output deep_masked);
endinterface

// >>> hw/dcr_gate_mask.sv
// masks the clock-gating registers with the feature capability word
`timescale 1ns/1ns
module dcr_gate_mask (
  input wire logic sys_clk,
  input wire logic nrst,
  dcr_gate_if.mask gif
);
  logic [31:0] run_q, run_d;
  logic [31:0] sleep_q, sleep_d;
  logic [31:0] deep_q, deep_d;

  // keep only present features except thermal bit 5 and synthesiser bit 4, which pass zero; clip the speed field to the limit
  function automatic logic [31:0] dcr_apply(input logic [31:0] raw, input logic [31:0] feat);
    logic [31:0] m;
    logic [dcr_pkg::FEAT_SPD_W-1:0] spd;
    logic [dcr_pkg::FEAT_SPD_W-1:0] lim;
    m = '0;
    m[dcr_pkg::FEAT_PWM_BIT] = raw[dcr_pkg::FEAT_PWM_BIT] & feat[dcr_pkg::FEAT_PWM_BIT];
    m[dcr_pkg::FEAT_CONV0_BIT] = raw[dcr_pkg::FEAT_CONV0_BIT] & feat[dcr_pkg::FEAT_CONV0_BIT];
    m[dcr_pkg::FEAT_WDOG_BIT] = raw[dcr_pkg::FEAT_WDOG_BIT] & feat[dcr_pkg::FEAT_WDOG_BIT];
    m[dcr_pkg::FEAT_TRACE_BIT] = raw[dcr_pkg::FEAT_TRACE_BIT] & feat[dcr_pkg::FEAT_TRACE_BIT];
    m[dcr_pkg::FEAT_TWD_BIT] = raw[dcr_pkg::FEAT_TWD_BIT] & feat[dcr_pkg::FEAT_TWD_BIT];
    m[dcr_pkg::FEAT_BSCAN_BIT] = raw[dcr_pkg::FEAT_BSCAN_BIT] & feat[dcr_pkg::FEAT_BSCAN_BIT];
    spd = raw[dcr_pkg::FEAT_SPD_LSB +: dcr_pkg::FEAT_SPD_W];
    lim = feat[dcr_pkg::FEAT_SPD_LSB +: dcr_pkg::FEAT_SPD_W];
    m[dcr_pkg::FEAT_SPD_LSB +: dcr_pkg::FEAT_SPD_W] = (spd > lim) ? lim : spd;
    return m;
  endfunction

  always_comb begin
    run_d = dcr_apply(gif.run_raw, gif.feature);
    sleep_d = dcr_apply(gif.sleep_raw, gif.feature);
    deep_d = dcr_apply(gif.deep_raw, gif.feature);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= dcr_pkg::RESET_WORD;
      sleep_q <= dcr_pkg::RESET_WORD;
      deep_q <= dcr_pkg::RESET_WORD;
    end else begin
      run_q <= run_d;
      sleep_q <= sleep_d;
      deep_q <= deep_d;
    end
  end

  assign gif.run_masked = run_q;
  assign gif.sleep_masked = sleep_q;
  assign gif.deep_masked = deep_q;
endmodule

// >>> hw/dcr_top.sv
// device capability register bank behind an avalon-mm slave
`timescale 1ns/1ns
module dcr_top #(
  parameter logic [1:0] QUALIFICATION_STATUS_CODE_CODE = dcr_pkg::ID_QUALIFICATION_STATUS_CODE_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [31:0] run_gate_raw,
  input wire logic [31:0] sleep_gate_raw,
  input wire logic [31:0] deep_gate_raw,
  output logic [31:0] run_gate_masked,
  output logic [31:0] sleep_gate_masked,
  output logic [31:0] deep_gate_masked
);
  localparam logic [31:0] MEM_SIZE_WORD =
    {dcr_pkg::RAM_SIZE_CODE, dcr_pkg::NVM_SIZE_CODE};

  function automatic logic [31:0] dcr_feature_word();
    logic [31:0] w;
    w = '0;
    w[dcr_pkg::FEAT_PWM_BIT] = 1'b1;
    w[dcr_pkg::FEAT_CONV0_BIT] = 1'b1;
    w[dcr_pkg::FEAT_SPD_LSB +: dcr_pkg::FEAT_SPD_W] = dcr_pkg::FEAT_SPD_LIMIT;
    w[dcr_pkg::FEAT_THERM_BIT] = 1'b1;
    w[dcr_pkg::FEAT_SYNTH_BIT] = 1'b1;
    w[dcr_pkg::FEAT_WDOG_BIT] = 1'b1;
    w[dcr_pkg::FEAT_TRACE_BIT] = 1'b1;
    w[dcr_pkg::FEAT_TWD_BIT] = 1'b1;
    w[dcr_pkg::FEAT_BSCAN_BIT] = 1'b1;
    return w;
  endfunction

  function automatic logic [31:0] dcr_id_word(input logic [1:0] qualification_status_code);
    logic [31:0] w;
    w = '0;
    w[dcr_pkg::ID_THERM_LSB +: 3] = dcr_pkg::ID_THERM_CODE;
    w[dcr_pkg::ID_PKG_LSB +: 2] = dcr_pkg::ID_PKG_CODE;
    w[dcr_pkg::ID_ENV_BIT] = dcr_pkg::ID_ENV_CODE;
    w[dcr_pkg::ID_QUALIFICATION_STATUS_CODE_LSB +: 2] = qualification_status_code;
    return w;
  endfunction

  localparam logic [31:0] FEATURE_WORD = dcr_feature_word();

  dcr_pkg::dcr_bus_state_t state_q, state_d;
  logic [31:0] rdata_q, rdata_d;
  logic req;

  dcr_gate_if gif();

  assign req = avs_read | avs_write;

  // one wait cycle per access; writes land nowhere
  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    case (state_q)
      dcr_pkg::DCR_IDLE: begin
        if (req) begin
          state_d = dcr_pkg::DCR_ACK;
          rdata_d = dcr_pkg::RESET_WORD;
          if (avs_read) begin
            if (avs_address == dcr_pkg::OFS_PART_ID_ONE) begin
              rdata_d = dcr_id_word(QUALIFICATION_STATUS_CODE_CODE);
            end else if (avs_address == dcr_pkg::OFS_MEM_SIZE_CAP) begin
              rdata_d = MEM_SIZE_WORD;
            end else if (avs_address == dcr_pkg::OFS_FEATURE_CAP) begin
              rdata_d = FEATURE_WORD;
            end else begin
              rdata_d = dcr_pkg::RESET_WORD;
            end
          end
        end
      end
      dcr_pkg::DCR_ACK: begin
        state_d = dcr_pkg::DCR_IDLE;
      end
      default: begin
        state_d = dcr_pkg::DCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= dcr_pkg::DCR_IDLE;
      rdata_q <= dcr_pkg::RESET_WORD;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = req & (state_q != dcr_pkg::DCR_ACK);
  assign avs_readdata = rdata_q;

  assign gif.feature = FEATURE_WORD;
  assign gif.run_raw = run_gate_raw;
  assign gif.sleep_raw = sleep_gate_raw;
  assign gif.deep_raw = deep_gate_raw;

  dcr_gate_mask u_mask (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .gif(gif.mask)
  );

  assign run_gate_masked = gif.run_masked;
  assign sleep_gate_masked = gif.sleep_masked;
  assign deep_gate_masked = gif.deep_masked;
endmodule

// >>> bench/dcr_top_properties.sv
// concurrent checks on the ports of the capability register bank
`timescale 1ns/1ns
module dcr_top_checker #(
  parameter logic [1:0] QUALIFICATION_STATUS_CODE_CODE = 2'h0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [31:0] run_gate_raw,
  input wire logic [31:0] sleep_gate_raw,
  input wire logic [31:0] deep_gate_raw,
  input wire logic [31:0] run_gate_masked,
  input wire logic [31:0] sleep_gate_masked,
  input wire logic [31:0] deep_gate_masked
);
  function automatic logic [31:0] exp_mask(input logic [31:0] r);
    logic [31:0] m;
    m = r & 32'h0011000f;
    m[9:8] = (r[9:8] > 2'h1) ? 2'h1 : r[9:8];
    return m;
  endfunction
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait cycle");
  AST_MEM: assert property (avs_read && !avs_waitrequest && avs_address == 12'h008 |-> avs_readdata == 32'h00ff003f)
    else $error("memory size word wrong");
  AST_FEAT: assert property (avs_read && !avs_waitrequest && avs_address == 12'h010 |-> avs_readdata[5:0] == 6'h3f)
    else $error("feature bits wrong");
  AST_ID: assert property (avs_read && !avs_waitrequest && avs_address == 12'h004 |-> avs_readdata[12:0] == {5'h00, 3'h1, 2'h1, 1'b1, QUALIFICATION_STATUS_CODE_CODE})
    else $error("identification fields wrong");
  AST_RUN_ZERO: assert property (1'b1 |=> (run_gate_masked & ~32'h0011030f) == 32'h0)
    else $error("unmasked gating bit passed");
  AST_CLIP: assert property (run_gate_raw[9:8] > 2'h1 |=> run_gate_masked[9:8] == 2'h1)
    else $error("speed setting not clipped");
  AST_SLEEP: assert property (1'b1 |=> sleep_gate_masked == exp_mask($past(sleep_gate_raw)))
    else $error("sleep gating mask wrong");
  AST_DEEP: assert property ($past(nrst) |-> deep_gate_masked == exp_mask($past(deep_gate_raw)))
    else $error("deep sleep gating mask wrong");
endmodule
bind dcr_top dcr_top_checker #(.QUALIFICATION_STATUS_CODE_CODE(QUALIFICATION_STATUS_CODE_CODE)) dcr_top_checker_i (.*);

// >>> bench/tb.sv
// self-checking bench for the capability register bank
`timescale 1ns/1ns
module tb;
  localparam logic [1:0] QUALIFICATION_STATUS_CODE = 2'h1;
  localparam logic [31:0] PAT [5] = '{32'hffffffff, 32'h0, 32'h00000300, 32'h00000100, 32'ha5a5a6a5};
  logic sys_clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, wq;
  logic [11:0] adr = 12'h000;
  logic [3:0] be = 4'hf;
  logic [31:0] wd = '0, rdata, rg = '0, sg = '0, dg = '0, rm, sm, dm, got;
  int n_fail = 0, checks = 0;
  always #25 sys_clk = ~sys_clk;
  dcr_top #(.QUALIFICATION_STATUS_CODE_CODE(QUALIFICATION_STATUS_CODE)) dcr_top_i (.sys_clk(sys_clk), .nrst(nrst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wq),
    .run_gate_raw(rg), .sleep_gate_raw(sg), .deep_gate_raw(dg), .run_gate_masked(rm),
    .sleep_gate_masked(sm), .deep_gate_masked(dm));
  function automatic logic [31:0] em(input logic [31:0] r);
    logic [31:0] m;
    m = r & 32'h0011000f;
    m[9:8] = (r[9:8] == 2'h0) ? 2'h0 : 2'h1;
    return m;
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task conclude;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // holds the request until the edge where waitrequest is low
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    // wq and rdata read here still hold their values from before this edge
    do begin
      @(posedge sys_clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) chk({31'h0, wq}, 32'h0);
    @(posedge sys_clk);
  endtask
  task idle;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task t_regs;
    bus(1'b0, 12'h008, '0); chk(got, 32'h00ff003f);
    bus(1'b0, 12'h010, '0); chk(got, 32'h0011013f);
    bus(1'b0, 12'h004, '0); chk(got, {24'h0, 3'h1, 2'h1, 1'b1, QUALIFICATION_STATUS_CODE});
    idle;
    $display("test regs done");
  endtask
  task t_write;
    bus(1'b1, 12'h008, '1); bus(1'b0, 12'h008, '0); chk(got, 32'h00ff003f);
    bus(1'b1, 12'h010, '0); bus(1'b0, 12'h010, '0); chk(got, 32'h0011013f);
    bus(1'b1, 12'h004, '1); bus(1'b0, 12'h004, '0); chk(got, {24'h0, 8'h2c | QUALIFICATION_STATUS_CODE});
    bus(1'b0, 12'h00c, '0); chk(got, 32'h0);
    idle;
    $display("test write done");
  endtask
  task t_gate;
    for (int i = 0; i < 5; i++) begin
      rg <= PAT[i];
      sg <= ~PAT[i];
      dg <= PAT[i] ^ 32'h00000200;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(rm, em(PAT[i]));
      chk(sm, em(~PAT[i]));
      chk(dm, em(PAT[i] ^ 32'h00000200));
      @(posedge sys_clk);
    end
    $display("test gate done");
  endtask
  // reset in mid-run clears read data and the run masked output, then run masking resumes
  task t_reset;
    bus(1'b0, 12'h008, '0);
    rg <= 32'hffffffff;
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(negedge sys_clk);
    chk(rm, 32'h0);
    chk(rdata, 32'h0);
    @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(rm, em(32'hffffffff));
    @(posedge sys_clk);
    $display("test reset done");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_regs;
    t_write;
    t_gate;
    t_reset;
    conclude;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    n_fail++;
    conclude;
  end
endmodule
